// ===== pkg/psf_pkg.sv
// Purpose: Shared constants and carriers for the packet sync/frame config
// Assumes: 8-bit register port, one 100 MHz clock
// Notes:   Offsets are byte addresses on the plain register port
package psf_pkg;

	localparam int CLK_MHZ = 100;

	// Register offsets
	localparam logic [7:0] OFF_PRE   = 8'h39;
	localparam logic [7:0] OFF_DLA0  = 8'h3a;
	localparam logic [7:0] OFF_DLA1  = 8'h3b;
	localparam logic [7:0] OFF_DLA2  = 8'h3c;
	localparam logic [7:0] OFF_DLA3  = 8'h3d;
	localparam logic [7:0] OFF_DLB0  = 8'h3e;
	localparam logic [7:0] OFF_DLB1  = 8'h3f;
	localparam logic [7:0] OFF_DLB2  = 8'h40;
	localparam logic [7:0] OFF_DLB3  = 8'h41;
	localparam logic [7:0] OFF_TXPR  = 8'h42;
	localparam logic [7:0] OFF_RXLEN = 8'h43;
	localparam logic [7:0] OFF_TOL   = 8'h44;
	localparam logic [7:0] OFF_PKT   = 8'h45;
	localparam logic [7:0] OFF_STAT  = 8'h50;

	// Delimiter length codes
	localparam logic [2:0] DLEN_8  = 3'h1;
	localparam logic [2:0] DLEN_16 = 3'h2;
	localparam logic [2:0] DLEN_24 = 3'h3;
	localparam logic [2:0] DLEN_32 = 3'h4;

	// Fixed preamble bytes accepted in dual mode
	localparam logic [7:0] PRE_ALT_A = 8'haa;
	localparam logic [7:0] PRE_ALT_B = 8'h55;
	// Receive compare length limits, in bytes
	localparam logic [3:0] RXLEN_CLAMP = 4'h5;
	localparam logic [2:0] RXLEN_MAX   = 3'h4;
	localparam logic [2:0] RXLEN_MIN   = 3'h1;

	typedef struct packed {
		logic [7:0]  pre;
		logic [31:0] dla;
		logic [31:0] dlb;
		logic [7:0]  txpr;
		logic [3:0]  rxpr;
		logic        dual;
		logic [2:0]  dlen;
		logic [3:0]  dtol;
		logic [3:0]  ptol;
		logic        addr_stat;
		logic        grp;
		logic        rej_late;
		logic        whiten;
		logic        ed_app;
		logic        auto_tx;
		logic        fmt_g;
		logic        idle_det;
	} psf_cfg_t;

	localparam psf_cfg_t CFG_RST = '{
		pre: 8'h55, dla: 32'h0000_00a7, dlb: 32'h0000_00a7,
		txpr: 8'h04, rxpr: 4'h0, dual: 1'b0, dlen: 3'h2,
		dtol: 4'h0, ptol: 4'h0, addr_stat: 1'b0, grp: 1'b0,
		rej_late: 1'b0, whiten: 1'b1, ed_app: 1'b1, auto_tx: 1'b0,
		fmt_g: 1'b1, idle_det: 1'b1};

	// Settings in force for one packet
	typedef struct packed {
		logic [31:0] pattern;
		logic [31:0] mask;
		logic [5:0]  nbits;
		logic [5:0]  dshift;
		logic        delim_en;
		logic [2:0]  rx_bytes;
		logic [7:0]  pre;
		logic        dual;
		logic [3:0]  dtol;
		logic [3:0]  ptol;
	} psf_sync_t;

	function automatic logic [5:0] psf_ones(input logic [31:0] v);
		logic [5:0] n;
		n = 6'h00;
		for (int i = 0; i < 32; i++) begin
			n = n + {5'h00, v[i]};
		end
		return n;
	endfunction

endpackage

// ===== hw/psf_sync_eval.sv
// Purpose: Turns programmed settings into the settings a packet uses
// Assumes: Purely combinational, driven from registered settings
// Notes:   Result is captured by the top only between packets
`timescale 1ns/1ps
`default_nettype none
module psf_sync_eval (
	// Programmed settings
	input  wire psf_pkg::psf_cfg_t  cfg,
	input  wire logic               manchester_en,
	// Effective settings
	output var  psf_pkg::psf_sync_t eff
);

	always_comb begin
		eff = '0;
		eff.pattern = cfg.grp ? cfg.dlb : cfg.dla;
		eff.delim_en = 1'b1;
		case (cfg.dlen)
			psf_pkg::DLEN_8:  eff.nbits = 6'd8;
			psf_pkg::DLEN_16: eff.nbits = 6'd16;
			psf_pkg::DLEN_24: eff.nbits = 6'd24;
			psf_pkg::DLEN_32: eff.nbits = 6'd32;
			default: begin
				eff.nbits = 6'd32;
				eff.delim_en = 1'b0;
			end
		endcase
		eff.dshift = 6'd32 - eff.nbits;
		eff.mask = 32'hffff_ffff >> eff.dshift;
		eff.pattern = eff.pattern & eff.mask;
		if (cfg.rxpr == 4'h0) begin
			eff.rx_bytes = psf_pkg::RXLEN_MIN;
		end else if (cfg.rxpr >= psf_pkg::RXLEN_CLAMP) begin
			eff.rx_bytes = psf_pkg::RXLEN_MAX;
		end else begin
			eff.rx_bytes = cfg.rxpr[2:0];
		end
		eff.pre = cfg.pre;
		eff.dual = cfg.dual;
		// Tolerances are meaningless on Manchester symbols
		eff.dtol = manchester_en ? 4'h0 : cfg.dtol;
		eff.ptol = (manchester_en || cfg.dual) ? 4'h0 : cfg.ptol;
	end

endmodule
`default_nettype wire

// ===== hw/psf_top.sv
// Purpose: Packet sync and framing settings with delimiter/preamble engines
// Assumes: Bit streams, ticks and counts come from modem logic on clk
// Notes:   Sync settings are frozen per packet, other settings apply at once; software may write any time
`timescale 1ns/1ps
`default_nettype none
module psf_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Modem conditions
	input  wire logic        manchester_en,
	input  wire logic        fec_en,
	input  wire logic        rx_mode,
	input  wire logic        rx_end,
	input  wire logic        tx_busy,
	input  wire logic        hdr_whiten_flag,
	// Receive bit stream
	input  wire logic        rx_bit,
	input  wire logic        rx_bit_tick,
	output logic             preamble_found,
	output logic             delim_found,
	// Transmit delimiter stream
	input  wire logic        tx_delim_start,
	input  wire logic        tx_bit_tick,
	output logic             tx_delim_bit,
	output logic             tx_delim_valid,
	// Packet handling
	input  wire logic        addr_reject,
	input  wire logic [10:0] tx_wr_count,
	input  wire logic [10:0] tx_len_total,
	input  wire logic [10:0] fast_tx_trig,
	output logic             auto_tx_start,
	output logic             discard_now,
	// Settings to the modem
	output logic      [7:0]  tx_preamble_len,
	output logic             delim_cmp_en,
	output logic             whiten_en,
	output logic             addr_status_en,
	output logic             energy_value_append,
	output logic             fmt_g_sel,
	output logic             idle_detect_en
);

	typedef struct packed {
		psf_pkg::psf_cfg_t  cfg;
		psf_pkg::psf_sync_t act;
		logic [7:0]         rdata;
		logic [31:0]        rx_sh;
		logic [7:0]         pre_sh;
		logic [2:0]         bitc;
		logic [2:0]         pre_cnt;
		logic               pre_lock;
		logic               dfound;
		logic [4:0]         tx_idx;
		logic               tx_on;
		logic               tx_bit;
		logic               fired;
		logic               autostart;
		logic               rej_pend;
		logic               discard;
		logic               whiten;
	} psf_state_t;

	psf_state_t         s_q;
	psf_state_t         s_d;
	psf_pkg::psf_sync_t eff;
	logic               busy;

	psf_sync_eval u_eval (
		.cfg           (s_q.cfg),
		.manchester_en (manchester_en),
		.eff           (eff)
	);

	// A packet is in flight from preamble lock or delimiter start to its end
	assign busy = s_q.pre_lock | s_q.tx_on | tx_busy;

	function automatic logic [7:0] rd_byte(input psf_state_t s,
		input logic [7:0] a, input logic bsy);
		case (a)
			psf_pkg::OFF_PRE:   rd_byte = s.cfg.pre;
			psf_pkg::OFF_DLA0:  rd_byte = s.cfg.dla[7:0];
			psf_pkg::OFF_DLA1:  rd_byte = s.cfg.dla[15:8];
			psf_pkg::OFF_DLA2:  rd_byte = s.cfg.dla[23:16];
			psf_pkg::OFF_DLA3:  rd_byte = s.cfg.dla[31:24];
			psf_pkg::OFF_DLB0:  rd_byte = s.cfg.dlb[7:0];
			psf_pkg::OFF_DLB1:  rd_byte = s.cfg.dlb[15:8];
			psf_pkg::OFF_DLB2:  rd_byte = s.cfg.dlb[23:16];
			psf_pkg::OFF_DLB3:  rd_byte = s.cfg.dlb[31:24];
			psf_pkg::OFF_TXPR:  rd_byte = s.cfg.txpr;
			psf_pkg::OFF_RXLEN: rd_byte = {s.cfg.rxpr, s.cfg.dual, s.cfg.dlen};
			psf_pkg::OFF_TOL:   rd_byte = {s.cfg.dtol, s.cfg.ptol};
			psf_pkg::OFF_PKT:   rd_byte = {s.cfg.addr_stat, s.cfg.grp,
				s.cfg.rej_late, s.cfg.whiten, s.cfg.ed_app, s.cfg.auto_tx,
				s.cfg.fmt_g, s.cfg.idle_det};
			psf_pkg::OFF_STAT:  rd_byte = {4'h0, s.fired, s.dfound,
				s.pre_lock, bsy};
			default:            rd_byte = 8'h00;
		endcase
	endfunction

	always_comb begin
		logic [31:0] sh;
		logic [7:0]  psh;
		logic        pm;
		logic [2:0]  pc;
		logic        reach;
		sh = 32'h0;
		psh = 8'h00;
		pm = 1'b0;
		pc = 3'h0;
		reach = 1'b0;
		s_d = s_q;

		// Register writes; unmapped and read-only offsets are ignored
		s_d.rdata = reg_rd ? rd_byte(s_q, reg_addr, busy) : 8'h00;
		if (reg_wr) begin
			case (reg_addr)
				psf_pkg::OFF_PRE:   s_d.cfg.pre = reg_wdata;
				psf_pkg::OFF_DLA0:  s_d.cfg.dla[7:0] = reg_wdata;
				psf_pkg::OFF_DLA1:  s_d.cfg.dla[15:8] = reg_wdata;
				psf_pkg::OFF_DLA2:  s_d.cfg.dla[23:16] = reg_wdata;
				psf_pkg::OFF_DLA3:  s_d.cfg.dla[31:24] = reg_wdata;
				psf_pkg::OFF_DLB0:  s_d.cfg.dlb[7:0] = reg_wdata;
				psf_pkg::OFF_DLB1:  s_d.cfg.dlb[15:8] = reg_wdata;
				psf_pkg::OFF_DLB2:  s_d.cfg.dlb[23:16] = reg_wdata;
				psf_pkg::OFF_DLB3:  s_d.cfg.dlb[31:24] = reg_wdata;
				psf_pkg::OFF_TXPR:  s_d.cfg.txpr = reg_wdata;
				psf_pkg::OFF_RXLEN: begin
					{s_d.cfg.rxpr, s_d.cfg.dual, s_d.cfg.dlen} = reg_wdata;
				end
				psf_pkg::OFF_TOL: begin
					{s_d.cfg.dtol, s_d.cfg.ptol} = reg_wdata;
				end
				psf_pkg::OFF_PKT: begin
					{s_d.cfg.addr_stat, s_d.cfg.grp, s_d.cfg.rej_late,
						s_d.cfg.whiten, s_d.cfg.ed_app, s_d.cfg.auto_tx,
						s_d.cfg.fmt_g, s_d.cfg.idle_det} = reg_wdata;
				end
				default: ;
			endcase
		end

		// Freeze settings while a packet is in flight
		if (!busy) begin
			s_d.act = eff;
		end

		// Receive: preamble lock, then delimiter search, LSB first
		if (rx_mode && rx_bit_tick) begin
			sh = {rx_bit, s_q.rx_sh[31:1]};
			psh = {rx_bit, s_q.pre_sh[7:1]};
			s_d.rx_sh = sh;
			s_d.pre_sh = psh;
			s_d.bitc = s_q.bitc + 3'h1;
			if (s_q.act.dual) begin
				pm = (psh == psf_pkg::PRE_ALT_A) ||
					(psh == psf_pkg::PRE_ALT_B);
			end else begin
				pm = psf_pkg::psf_ones({24'h0, psh ^ s_q.act.pre}) <=
					{2'b00, s_q.act.ptol};
			end
			if (!s_q.pre_lock) begin
				pc = s_q.pre_cnt;
				if (s_q.pre_cnt == 3'h0) begin
					if (pm) begin
						pc = 3'h1;
						s_d.bitc = 3'h0;
					end
				end else if (s_q.bitc == 3'h7) begin
					pc = pm ? s_q.pre_cnt + 3'h1 : 3'h0;
				end
				reach = (pc != 3'h0) && (pc >= s_q.act.rx_bytes);
				s_d.pre_cnt = reach ? 3'h0 : pc;
				s_d.pre_lock = reach;
			end else if (!s_q.dfound && s_q.act.delim_en) begin
				if (psf_pkg::psf_ones(((sh >> s_q.act.dshift) ^
					s_q.act.pattern) & s_q.act.mask) <=
					{2'b00, s_q.act.dtol}) begin
					s_d.dfound = 1'b1;
				end
			end
		end
		if (rx_end || !rx_mode) begin
			s_d.pre_lock = 1'b0;
			s_d.dfound = 1'b0;
			s_d.pre_cnt = 3'h0;
		end

		// Transmit delimiter serialiser, low byte and low bit first
		if (!s_q.tx_on) begin
			if (tx_delim_start && s_q.act.delim_en) begin
				s_d.tx_on = 1'b1;
				s_d.tx_idx = 5'h00;
				s_d.tx_bit = s_q.act.pattern[0];
			end
		end else if (tx_bit_tick) begin
			if ({1'b0, s_q.tx_idx} + 6'd1 == s_q.act.nbits) begin
				s_d.tx_on = 1'b0;
				s_d.tx_bit = 1'b0;
			end else begin
				s_d.tx_idx = s_q.tx_idx + 5'h01;
				s_d.tx_bit = s_q.act.pattern[s_d.tx_idx];
			end
		end

		// Whitening per format; with FEC only received data is whitened
		if (fec_en) begin
			s_d.whiten = s_q.cfg.whiten && rx_mode;
		end else begin
			s_d.whiten = s_q.cfg.whiten &&
				(!s_q.cfg.fmt_g || hdr_whiten_flag);
		end

		// Address reject: a late discard waits for the end of reception
		s_d.discard = 1'b0;
		if (addr_reject && !s_q.cfg.rej_late) begin
			s_d.discard = 1'b1;
		end
		if (s_q.rej_pend && rx_end) begin
			s_d.discard = 1'b1;
			s_d.rej_pend = 1'b0;
		end
		if (addr_reject && s_q.cfg.rej_late) begin
			s_d.rej_pend = 1'b1;
		end

		// Auto transmit fires once per buffer fill
		s_d.autostart = s_q.cfg.auto_tx && !s_q.fired && !tx_busy &&
			(tx_wr_count != 11'h000) &&
			((tx_wr_count >= tx_len_total) ||
			((fast_tx_trig != 11'h000) &&
			(tx_wr_count >= fast_tx_trig)));
		if (s_d.autostart) begin
			s_d.fired = 1'b1;
		end else if (tx_wr_count == 11'h000) begin
			s_d.fired = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.cfg <= psf_pkg::CFG_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata           = s_q.rdata;
	assign preamble_found      = s_q.pre_lock;
	assign delim_found         = s_q.dfound;
	assign tx_delim_bit        = s_q.tx_bit;
	assign tx_delim_valid      = s_q.tx_on;
	assign auto_tx_start       = s_q.autostart;
	assign discard_now         = s_q.discard;
	assign tx_preamble_len     = s_q.cfg.txpr;
	assign delim_cmp_en        = s_q.act.delim_en;
	assign whiten_en           = s_q.whiten;
	assign addr_status_en      = s_q.cfg.addr_stat;
	assign energy_value_append = s_q.cfg.ed_app;
	assign fmt_g_sel           = s_q.cfg.fmt_g;
	assign idle_detect_en      = s_q.cfg.idle_det;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_pattern_sel;
		!busy |=> s_q.act.pattern == (($past(s_q.cfg.grp) ?
			$past(s_q.cfg.dlb) : $past(s_q.cfg.dla)) & s_q.act.mask);
	endproperty
	a_pattern_sel: assert property (p_pattern_sel)
		else $error("delimiter pattern not from selected group");

	property p_tx_lsb_first;
		(!s_q.tx_on && tx_delim_start && s_q.act.delim_en) |=>
			tx_delim_valid && tx_delim_bit == $past(s_q.act.pattern[0]);
	endproperty
	a_tx_lsb_first: assert property (p_tx_lsb_first)
		else $error("delimiter did not start with bit zero");

	property p_bad_len;
		$rose(s_q.dfound) |-> $past(s_q.act.delim_en);
	endproperty
	a_bad_len: assert property (p_bad_len)
		else $error("delimiter found while comparison disabled");

	property p_rx_bytes;
		(!busy && s_q.cfg.rxpr == 4'h0) |=> s_q.act.rx_bytes == 3'h1 ##0
			(s_q.act.rx_bytes inside {[3'h1:3'h4]});
	endproperty
	a_rx_bytes: assert property (p_rx_bytes)
		else $error("receive compare length out of range");

	property p_dual_zero_tol;
		(!busy && s_q.cfg.dual) |=> s_q.act.ptol == 4'h0;
	endproperty
	a_dual_zero_tol: assert property (p_dual_zero_tol)
		else $error("preamble tolerance not zero in dual mode");

	property p_manchester_tol;
		(!busy && manchester_en) |=> s_q.act.ptol == 4'h0 &&
			s_q.act.dtol == 4'h0;
	endproperty
	a_manchester_tol: assert property (p_manchester_tol)
		else $error("tolerance applied under Manchester coding");

	property p_reject_now;
		(addr_reject && !s_q.cfg.rej_late) |=> discard_now;
	endproperty
	a_reject_now: assert property (p_reject_now)
		else $error("immediate discard missing");

	property p_reject_late;
		(addr_reject && s_q.cfg.rej_late && !rx_end && !s_q.rej_pend)
			|=> !discard_now;
	endproperty
	a_reject_late: assert property (p_reject_late)
		else $error("late discard fired before reception end");

	property p_fec_whiten;
		(fec_en && !rx_mode) |=> !whiten_en;
	endproperty
	a_fec_whiten: assert property (p_fec_whiten)
		else $error("whitening on transmit with FEC");

	property p_auto_pulse;
		auto_tx_start |-> $past(s_q.cfg.auto_tx) ##1 !auto_tx_start;
	endproperty
	a_auto_pulse: assert property (p_auto_pulse)
		else $error("auto transmit start without enable or too long");

	property p_freeze;
		busy |=> $stable(s_q.act);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("settings changed inside a packet");

	property p_fmt_write;
		(reg_wr && reg_addr == psf_pkg::OFF_PKT) |=>
			fmt_g_sel == $past(reg_wdata[1]) &&
			energy_value_append == $past(reg_wdata[3]);
	endproperty
	a_fmt_write: assert property (p_fmt_write)
		else $error("packet mode write not applied");

	c_delim: cover property ($rose(delim_found));
	c_discard: cover property (discard_now);
	c_auto: cover property (auto_tx_start);
	c_txdelim: cover property ($fell(tx_delim_valid));

endmodule
`default_nettype wire

// ===== verif/psf_peer.sv
// Purpose: Peer radio that sends a received bit stream to the block
// Assumes: One tick per bit, LSB first, pace set by gap
// Notes:   Line flips after each bit so a stale level never helps
`timescale 1ns/1ps
`default_nettype none
module psf_peer (
	// Clock
	input  wire logic clk,
	// Bits towards the receiver
	output logic      rx_bit,
	output logic      rx_bit_tick
);
	int gap = 1;

	initial begin
		rx_bit = 1'b0;
		rx_bit_tick = 1'b0;
	end

	task automatic send(input logic [63:0] f, input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			rx_bit <= f[k];
			rx_bit_tick <= 1'b1;
			@(posedge clk);
			rx_bit_tick <= 1'b0;
			rx_bit <= ~f[k];
			repeat (gap) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// ===== verif/packet_sync_frame_config_tb_top.sv
// Purpose: Self-checking bench for packet sync and framing settings
// Assumes: Bench plays software and modem; peer model sends bits
// Notes:   Expectations come from a register image kept in the bench
`timescale 1ns/1ps
`default_nettype none
module packet_sync_frame_config_tb_top;
	logic        clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
	logic        manchester_en = 1'b0, fec_en = 1'b0, rx_mode = 1'b0;
	logic        rx_end = 1'b0, tx_busy = 1'b0, hdr_whiten_flag = 1'b0;
	logic        tx_delim_start = 1'b0, tx_bit_tick = 1'b0;
	logic        addr_reject = 1'b0;
	logic [10:0] tx_wr_count = 11'h000, tx_len_total = 11'h000;
	logic [10:0] fast_tx_trig = 11'h000;
	wire  [7:0]  reg_rdata, tx_preamble_len;
	wire         rx_bit, rx_bit_tick, preamble_found, delim_found;
	wire         tx_delim_bit, tx_delim_valid, auto_tx_start, discard_now;
	wire         delim_cmp_en, whiten_en, addr_status_en, fmt_g_sel;
	wire         energy_value_append, idle_detect_en;
	int          failures = 0, comparisons = 0, cyc = 0;
	logic [7:0]  regm [logic [7:0]];
	logic [7:0]  rst_v [13] = '{8'h55, 8'ha7, 8'h00, 8'h00, 8'h00, 8'ha7,
		8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h00, 8'h1b};
	logic [7:0]  pats [8] = '{8'ha7, 8'h00, 8'h9c, 8'h0f, 8'h4e, 8'h3c,
		8'hf0, 8'h81};
	// Frame: bytes, cmp len, dual, byte, pre err, delim err, tol, manch,
	// group, length code
	int          cs [14][10] = '{
		'{1, 1, 0, 8'h55, 0, 0, 0, 0, 0, 2}, '{1, 0, 0, 8'h55, 0, 0, 0, 0, 1, 2},
		'{3, 7, 0, 8'h55, 0, 0, 0, 0, 0, 2}, '{4, 7, 0, 8'h55, 0, 0, 0, 0, 0, 4},
		'{1, 1, 0, 8'h55, 1, 0, 1, 0, 0, 2}, '{1, 1, 0, 8'h55, 1, 0, 0, 0, 0, 2},
		'{1, 1, 0, 8'h55, 0, 1, 1, 0, 0, 2}, '{1, 1, 0, 8'h55, 0, 1, 0, 0, 0, 2},
		'{1, 1, 0, 8'h55, 0, 1, 1, 1, 0, 2}, '{2, 2, 1, 8'haa, 0, 0, 0, 0, 0, 2},
		'{1, 1, 1, 8'haa, 1, 0, 1, 0, 0, 2}, '{1, 1, 1, 8'h55, 0, 0, 0, 0, 0, 1},
		'{1, 1, 0, 8'h55, 0, 0, 0, 0, 0, 5}, '{2, 1, 0, 8'h55, 0, 0, 0, 0, 1, 3}};

	psf_top DUT (
		.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.manchester_en, .fec_en, .rx_mode, .rx_end, .tx_busy,
		.hdr_whiten_flag, .rx_bit, .rx_bit_tick, .preamble_found,
		.delim_found, .tx_delim_start, .tx_bit_tick, .tx_delim_bit,
		.tx_delim_valid, .addr_reject, .tx_wr_count, .tx_len_total,
		.fast_tx_trig, .auto_tx_start, .discard_now, .tx_preamble_len,
		.delim_cmp_en, .whiten_en, .addr_status_en, .energy_value_append,
		.fmt_g_sel, .idle_detect_en);

	psf_peer peer (.clk, .rx_bit, .rx_bit_tick);

	initial begin
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			finish_test;
		end
	end

	task automatic finish_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		if (regm.exists(a)) regm[a] = d;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", reg_rdata, regm.exists(a) ? regm[a] : 8'h00);
	endtask

	task automatic cfg_chk;
		logic [7:0] p;
		p = regm[8'h45];
		repeat (3) @(posedge clk);
		#1;
		chk("tx_preamble_len", tx_preamble_len, regm[8'h42]);
		chk("delim_cmp_en", delim_cmp_en, regm[8'h43][2:0] inside {[1:4]});
		chk("addr_status_en", addr_status_en, p[7]);
		chk("energy_value_append", energy_value_append, p[3]);
		chk("fmt_g_sel", fmt_g_sel, p[1]);
		chk("idle_detect_en", idle_detect_en, p[0]);
	endtask

	function automatic logic [1:0] exp_rx(input int c[10]);
		int need, t;
		logic pok;
		need = c[1] == 0 ? 1 : (c[1] > 4 ? 4 : c[1]);
		t = c[7] ? 0 : c[6];
		if (c[2]) pok = (c[3] == 8'haa || c[3] == 8'h55) && c[4] == 0;
		else pok = c[4] <= t;
		pok = pok && c[0] >= need;
		return {pok && c[9] >= 1 && c[9] <= 4 && c[5] <= t, pok};
	endfunction

	initial begin
		int s, i, j, k, nb;
		int c[10];
		logic [31:0] pat;
		logic [63:0] f;
		logic [1:0] e;
		void'($urandom(38));
		for (i = 0; i < 13; i++) regm[8'h39 + 8'(i)] = rst_v[i];
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		for (i = 0; i < 13; i++) rd(8'h39 + 8'(i));
		rd(8'h60);
		cfg_chk;
		for (j = 0; j < 4; j++) begin
			for (i = 0; i < 13; i++) begin
				s = $urandom;
				if (i == 9) s[7:0] = 8'h04 + s[7:0] % 8'd252;
				if (i == 10) s[3] = 1'b0;
				wr(8'h39 + 8'(i), s[7:0]);
			end
			wr(8'h60, 8'hff);
			wr(8'h50, 8'hff);
			for (i = 0; i < 13; i++) rd(8'h39 + 8'(i));
			rd(8'h60);
			cfg_chk;
		end
		// Whitening over every mix of bit, format, FEC, direction, flag
		for (i = 0; i < 32; i++) begin
			wr(8'h45, {3'h0, i[0], 2'h2, i[1], 1'b1});
			fec_en <= i[2];
			rx_mode <= i[3];
			hdr_whiten_flag <= i[4];
			repeat (3) @(posedge clk);
			#1 chk("whiten_en", whiten_en, i[2] ? i[0] & i[3] :
				i[0] & (~i[1] | i[4]));
			@(posedge clk) rx_mode <= 1'b0;
		end
		fec_en <= 1'b0;
		for (i = 0; i < 2; i++) begin
			wr(8'h45, i ? 8'h3b : 8'h1b);
			@(posedge clk) addr_reject <= 1'b1;
			@(posedge clk) addr_reject <= 1'b0;
			#1 chk("discard_now", discard_now, !i);
			@(posedge clk) rx_end <= 1'b1;
			@(posedge clk) rx_end <= 1'b0;
			#1 chk("discard_now", discard_now, i);
		end
		wr(8'h45, 8'h1f);
		tx_len_total <= 11'd10;
		tx_busy <= 1'b1;
		tx_wr_count <= 11'd10;
		@(posedge clk);
		#1 chk("auto_tx_start", auto_tx_start, 0);
		@(posedge clk) tx_busy <= 1'b0;
		@(posedge clk);
		#1 chk("auto_tx_start", auto_tx_start, 1);
		@(posedge clk);
		#1 chk("auto_tx_start", auto_tx_start, 0);
		@(posedge clk) tx_wr_count <= 11'd0;
		fast_tx_trig <= 11'd5;
		tx_len_total <= 11'd40;
		@(posedge clk) tx_wr_count <= 11'd4;
		@(posedge clk);
		#1 chk("auto_tx_start", auto_tx_start, 0);
		@(posedge clk) tx_wr_count <= 11'd5;
		@(posedge clk);
		#1 chk("auto_tx_start", auto_tx_start, 1);
		// Quiet time after a buffer write with automatic send on
		repeat (15000) @(posedge clk);
		tx_busy <= 1'b1;
		// Leave transmit by clearing automatic send mid-transmission
		wr(8'h45, 8'h1b);
		tx_busy <= 1'b0;
		tx_wr_count <= 11'd0;
		@(posedge clk) tx_wr_count <= 11'd5;
		@(posedge clk);
		#1 chk("auto_tx_start", auto_tx_start, 0);
		for (k = 0; k < 6; k++) begin
			wr(8'h43, 8'(k));
			wr(8'h45, k[0] ? 8'h5b : 8'h1b);
			pat = k[0] ? {regm[8'h41], regm[8'h40], regm[8'h3f], regm[8'h3e]} :
				{regm[8'h3d], regm[8'h3c], regm[8'h3b], regm[8'h3a]};
			nb = (k >= 1 && k <= 4) ? 8 * k : 0;
			repeat (2) @(posedge clk);
			tx_delim_start <= 1'b1;
			@(posedge clk) tx_delim_start <= 1'b0;
			#1 chk("tx_delim_valid", tx_delim_valid, nb != 0);
			for (j = 0; j < nb; j++) begin
				chk("tx_delim_bit", tx_delim_bit, pat[j]);
				@(posedge clk) tx_bit_tick <= 1'b1;
				@(posedge clk) tx_bit_tick <= 1'b0;
				#1;
			end
			chk("tx_delim_valid", tx_delim_valid, 0);
		end
		for (i = 0; i < 8; i++) wr(8'h3a + 8'(i), pats[i]);
		for (k = 0; k < 14; k++) begin
			c = cs[k];
			@(posedge clk) rx_mode <= 1'b0;
			wr(8'h39, 8'(c[2] ? c[3] ^ 8'h66 : c[3]));
			wr(8'h43, {4'(c[1]), c[2][0], 3'(c[9])});
			wr(8'h44, {2{4'(c[6])}});
			wr(8'h45, c[8] ? 8'h5b : 8'h1b);
			manchester_en <= c[7][0];
			@(posedge clk) rx_mode <= 1'b1;
			nb = (c[9] >= 1 && c[9] <= 4) ? 8 * c[9] : 16;
			pat = c[8] ? {regm[8'h41], regm[8'h40], regm[8'h3f], regm[8'h3e]} :
				{regm[8'h3d], regm[8'h3c], regm[8'h3b], regm[8'h3a]};
			f = '0;
			for (i = 0; i < c[0]; i++) f[8*i +: 8] = 8'(c[3]);
			f[3] = f[3] ^ c[4][0];
			f = f | (64'(pat ^ (32'(c[5]) << 5)) << (8 * c[0]));
			peer.gap = 3 * (k % 2);
			peer.send(f, 8 * c[0] + nb);
			#1 e = exp_rx(c);
			chk("delim_cmp_en", delim_cmp_en, c[9] >= 1 && c[9] <= 4);
			chk("preamble_found", preamble_found, e[0]);
			chk("delim_found", delim_found, e[1]);
		end
		// Pattern rewritten mid-frame must not hit the frame in flight
		@(posedge clk) rx_mode <= 1'b0;
		@(posedge clk) rx_mode <= 1'b1;
		fork
			peer.send(f, 8 * c[0] + nb);
			begin
				repeat (60) @(posedge clk);
				wr(8'h3e, 8'h11);
			end
		join
		#1 chk("delim_found", delim_found, 1);
		finish_test;
	end
endmodule
`default_nettype wire
